//--- rtl/setsel_params.svh
// Constants of the parameter profile selector: offsets, fields, resets, timing.
// Notes on behaviour
// - Forced change needs override enabled and the target profile enabled.
// - Clearing override hands selection back to applied static request levels.
// - Active profile is readable; it shows profile 1 after reset.
// - Override selector: 0 none, 1 to 8 pick profiles; resets to 0.
// - A forced selection is latched, like a pulse request.
// - After override ends with no requests, the last forced profile stays.
// - Override ignores new application requests, but their levels still block remote requests; stays until cleared, resets disabled.
// - Remote and local panel changes need override enabled first.
// - Count setting enables profiles 1 to count plus one; resets to 0.
// - A newly enabled profile gets a load-defaults pulse.
// - Remote selector value 1 to 8 is applied as a profile request.
// - Remote request is refused below a profile held by a request level.
// - Eight one-bit request inputs, pulse or level, inactive at reset.
// - Profile 1 level blocks every other application and remote request.
// - A level on profile n blocks application and remote requests for profiles numbered above n.
// - A level on profile 8 never blocks anything.
// - No automatic return to profile 1.
// - A pulse-activated profile stays until another request is accepted.
// - Several new requests at once: the lowest profile number wins.
// - Request for a disabled profile fails, flags it, keeps the profile.
`ifndef SETSEL_PARAMS_SVH
`define SETSEL_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets.
// ----------------------------------------------------------------------------
`define SETSEL_OFS_OVR_EN     8'h00
`define SETSEL_OFS_OVR_SEL    8'h04
`define SETSEL_OFS_COUNT      8'h08
`define SETSEL_OFS_REMOTE_SEL 8'h0C
`define SETSEL_OFS_LOCAL_SEL  8'h10
`define SETSEL_OFS_ACTIVE     8'h14
`define SETSEL_OFS_STATUS     8'h18

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define SETSEL_BIT_FAIL_CFG   0
`define SETSEL_BIT_FAIL_FORCE 1
`define SETSEL_BIT_FAIL_LOW   2
`define SETSEL_POS_ENABLED    8

// ----------------------------------------------------------------------------
// Reset values and the level block mask.
// ----------------------------------------------------------------------------
`define SETSEL_RST_OVR_EN     1'h0
`define SETSEL_RST_SEL        4'h0
`define SETSEL_RST_COUNT      3'h0
`define SETSEL_RST_ACTIVE     3'h0
`define SETSEL_BLOCK_MASK     8'h7F

// ----------------------------------------------------------------------------
// Timing.
// ----------------------------------------------------------------------------
`define SETSEL_ACK_CYCLES     1

`endif

//--- rtl/setsel_pkg.sv
// Types shared by the parameter profile selector.
package setsel_pkg;

   typedef enum logic [1:0] {
      SETSEL_SRC_NONE,
      SETSEL_SRC_FORCE,
      SETSEL_SRC_REMOTE,
      SETSEL_SRC_LOCAL
   } setsel_src_t;

   typedef struct packed {
      logic       low_prio;
      logic       force_off;
      logic       not_cfg;
   } setsel_fail_t;

   typedef struct packed {
      setsel_src_t src;
      logic [2:0]  idx;
   } setsel_swreq_t;

endpackage

//--- rtl/setsel_lowest_set.sv
// Finds the lowest set bit of a vector and returns its index.
module setsel_lowest_set #(
   parameter int WIDTH = 8,
   parameter int IW    = 3
) (
   input  wire logic [WIDTH-1:0] vec,
   output logic                  any,
   output logic [IW-1:0]         idx
);

   logic [WIDTH-1:0] below;
   logic [WIDTH-1:0] onehot;

   // -------------------------------------------------------------------------
   // Prefix chain: a bit wins only if no lower bit is set.
   // -------------------------------------------------------------------------
   assign below[0]  = 1'b0;
   assign onehot[0] = vec[0];
   genvar g;
   generate
      for (g = 1; g < WIDTH; g++)
      begin : g_chain
         assign below[g]  = below[g-1] | vec[g-1];
         assign onehot[g] = vec[g] & ~below[g];
      end
   endgenerate

   always_comb
   begin
      idx = '0;
      for (int i = 0; i < WIDTH; i++)
      begin
         if (onehot[i])
         begin
            idx = idx | IW'(i);
         end
      end
      any = |vec;
   end

endmodule

//--- rtl/setsel_top.sv
// Parameter profile selector with a classic Wishbone register slave.
`include "setsel_params.svh"

module setsel_top
   import setsel_pkg::*;
#(
   parameter int NPROF = 8
) (
   input  wire logic        REF_CLK,
   input  wire logic        RST,
   input  wire logic [7:0]  REQ_IN,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   output logic      [3:0]  ACTIVE_PROFILE,
   output logic      [7:0]  ACTIVE_ONEHOT,
   output logic      [7:0]  PROFILE_ENABLED,
   output logic      [7:0]  LOAD_DEFAULTS,
   output logic             REQUEST_FAIL,
   output logic             OVERRIDE_ACTIVE
);

   // -------------------------------------------------------------------------
   // Declarations.
   // -------------------------------------------------------------------------
   logic          ack_reg;
   logic [31:0]   rdat_reg;
   logic          ovr_en_reg;
   logic          ovr_en_d_reg;
   logic [3:0]    ovr_sel_reg;
   logic [3:0]    remote_sel_reg;
   logic [3:0]    local_sel_reg;
   logic [2:0]    count_reg;
   logic [7:0]    req_prev_reg;
   logic [2:0]    active_reg;
   logic [2:0]    active_next;
   setsel_fail_t  fail_reg;
   setsel_fail_t  fail_evt;
   logic [7:0]    enabled_reg;
   logic [7:0]    enabled_next;
   logic [7:0]    load_reg;
   logic          req_fail_reg;
   logic [3:0]    act_num_reg;
   logic [7:0]    act_oh_reg;
   logic          ovr_out_reg;
   logic          wr_stb;
   logic          lane0;
   setsel_swreq_t swreq;
   logic [3:0]    wval;
   logic          ovr_fall;
   logic [7:0]    app_new;
   logic [7:0]    held_blk;
   logic          app_any;
   logic [2:0]    app_idx;
   logic [7:0]    app_below;
   logic [7:0]    sw_below;
   logic          app_ok;
   logic          sw_ok;
   logic [31:0]   rdat_next;

   // -------------------------------------------------------------------------
   // Wishbone slave: ack one cycle after the request, write at the ack edge.
   // -------------------------------------------------------------------------
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         ack_reg <= 1'b0;
      end
      else
      begin
         ack_reg <= WB_CYC_I & WB_STB_I & ~ack_reg;
      end
   end

   assign wr_stb = ack_reg & WB_CYC_I & WB_STB_I & WB_WE_I;
   assign lane0  = WB_SEL_I[0];
   assign wval   = WB_DAT_I[3:0];

   always_comb
   begin
      rdat_next = 32'h0000_0000;
      case (WB_ADR_I)
         `SETSEL_OFS_OVR_EN:     rdat_next[0]   = ovr_en_reg;
         `SETSEL_OFS_OVR_SEL:    rdat_next[3:0] = ovr_sel_reg;
         `SETSEL_OFS_COUNT:      rdat_next[2:0] = count_reg;
         `SETSEL_OFS_REMOTE_SEL: rdat_next[3:0] = remote_sel_reg;
         `SETSEL_OFS_LOCAL_SEL:  rdat_next[3:0] = local_sel_reg;
         `SETSEL_OFS_ACTIVE:     rdat_next[3:0] = 4'(active_reg) + 4'h1;
         `SETSEL_OFS_STATUS:
         begin
            rdat_next[2:0] = fail_reg;
            rdat_next[`SETSEL_POS_ENABLED +: 8] = enabled_reg;
         end
         default:                rdat_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         rdat_reg <= 32'h0000_0000;
      end
      else if (WB_CYC_I & WB_STB_I & ~ack_reg)
      begin
         rdat_reg <= rdat_next;
      end
   end

   // -------------------------------------------------------------------------
   // Settings written by software.
   // -------------------------------------------------------------------------
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         ovr_en_reg     <= `SETSEL_RST_OVR_EN;
         ovr_sel_reg    <= `SETSEL_RST_SEL;
         remote_sel_reg <= `SETSEL_RST_SEL;
         local_sel_reg  <= `SETSEL_RST_SEL;
         count_reg      <= `SETSEL_RST_COUNT;
      end
      else if (wr_stb & lane0)
      begin
         case (WB_ADR_I)
            `SETSEL_OFS_OVR_EN:     ovr_en_reg     <= WB_DAT_I[0];
            `SETSEL_OFS_OVR_SEL:    ovr_sel_reg    <= wval;
            `SETSEL_OFS_COUNT:      count_reg      <= WB_DAT_I[2:0];
            `SETSEL_OFS_REMOTE_SEL: remote_sel_reg <= wval;
            `SETSEL_OFS_LOCAL_SEL:  local_sel_reg  <= wval;
            default:                count_reg      <= count_reg;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Software profile requests: a write of 1 to 8 is one request.
   // -------------------------------------------------------------------------
   always_comb
   begin
      swreq.src = SETSEL_SRC_NONE;
      swreq.idx = 3'(wval - 4'h1);
      if (wr_stb & lane0 & (wval != 4'h0) & (wval <= 4'h8))
      begin
         case (WB_ADR_I)
            `SETSEL_OFS_OVR_SEL:    swreq.src = SETSEL_SRC_FORCE;
            `SETSEL_OFS_REMOTE_SEL: swreq.src = SETSEL_SRC_REMOTE;
            `SETSEL_OFS_LOCAL_SEL:  swreq.src = SETSEL_SRC_LOCAL;
            default:                swreq.src = SETSEL_SRC_NONE;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Application request inputs: edges are new requests, levels block.
   // -------------------------------------------------------------------------
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         req_prev_reg <= 8'h00;
         ovr_en_d_reg <= `SETSEL_RST_OVR_EN;
      end
      else
      begin
         req_prev_reg <= REQ_IN;
         ovr_en_d_reg <= ovr_en_reg;
      end
   end

   assign ovr_fall = ovr_en_d_reg & ~ovr_en_reg;
   // Levels present when override drops count as fresh requests.
   assign app_new  = ovr_en_reg ? 8'h00 :
                     (ovr_fall ? REQ_IN : (REQ_IN & ~req_prev_reg));
   // A level held on profile 8 never blocks.
   assign held_blk = REQ_IN & req_prev_reg & `SETSEL_BLOCK_MASK;

   setsel_lowest_set #(
      .WIDTH (8),
      .IW    (3)
   ) u_lowest (
      .vec (app_new),
      .any (app_any),
      .idx (app_idx)
   );

   assign app_below = 8'((9'h001 << app_idx) - 9'h001);
   assign sw_below  = 8'((9'h001 << swreq.idx) - 9'h001);

   // -------------------------------------------------------------------------
   // Acceptance and refusal.
   // -------------------------------------------------------------------------
   always_comb
   begin
      fail_evt = '0;
      app_ok   = 1'b0;
      sw_ok    = 1'b0;
      if (app_any)
      begin
         if (!enabled_reg[app_idx])
         begin
            fail_evt.not_cfg = 1'b1;
         end
         else if (|(held_blk & app_below))
         begin
            fail_evt.low_prio = 1'b1;
         end
         else
         begin
            app_ok = 1'b1;
         end
      end
      if (swreq.src != SETSEL_SRC_NONE)
      begin
         if (!ovr_en_reg)
         begin
            fail_evt.force_off = 1'b1;
         end
         else if (!enabled_reg[swreq.idx])
         begin
            fail_evt.not_cfg = 1'b1;
         end
         else if ((swreq.src == SETSEL_SRC_REMOTE) &&
                  (|(held_blk & sw_below)))
         begin
            fail_evt.low_prio = 1'b1;
         end
         else
         begin
            sw_ok = 1'b1;
         end
      end
   end

   always_comb
   begin
      active_next = active_reg;
      if (sw_ok)
      begin
         active_next = swreq.idx;
      end
      else if (app_ok)
      begin
         active_next = app_idx;
      end
   end

   // -------------------------------------------------------------------------
   // Active profile.
   // -------------------------------------------------------------------------
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         active_reg <= `SETSEL_RST_ACTIVE;
      end
      else
      begin
         active_reg <= active_next;
      end
   end

   // -------------------------------------------------------------------------
   // Refusal flags: sticky, write one to clear, a new event wins.
   // -------------------------------------------------------------------------
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         fail_reg     <= '0;
         req_fail_reg <= 1'b0;
      end
      else
      begin
         if (wr_stb & lane0 & (WB_ADR_I == `SETSEL_OFS_STATUS))
         begin
            fail_reg <= (fail_reg & ~WB_DAT_I[2:0]) | fail_evt;
         end
         else
         begin
            fail_reg <= fail_reg | fail_evt;
         end
         req_fail_reg <= |fail_evt;
      end
   end

   // -------------------------------------------------------------------------
   // Enabled profiles and default loading of newly enabled ones.
   // -------------------------------------------------------------------------
   assign enabled_next = 8'((9'h002 << count_reg) - 9'h001);

   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         enabled_reg <= 8'h01;
         load_reg    <= 8'h00;
      end
      else
      begin
         enabled_reg <= enabled_next;
         load_reg    <= enabled_next & ~enabled_reg;
      end
   end

   // -------------------------------------------------------------------------
   // Registered outputs.
   // -------------------------------------------------------------------------
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         act_num_reg <= 4'h1;
         act_oh_reg  <= 8'h01;
         ovr_out_reg <= 1'b0;
      end
      else
      begin
         act_num_reg <= 4'(active_next) + 4'h1;
         act_oh_reg  <= 8'(9'h001 << active_next);
         ovr_out_reg <= ovr_en_reg;
      end
   end

   assign WB_ACK_O        = ack_reg;
   assign WB_DAT_O        = rdat_reg;
   assign ACTIVE_PROFILE  = act_num_reg;
   assign ACTIVE_ONEHOT   = act_oh_reg;
   assign PROFILE_ENABLED = enabled_reg;
   assign LOAD_DEFAULTS   = load_reg;
   assign REQUEST_FAIL    = req_fail_reg;
   assign OVERRIDE_ACTIVE = ovr_out_reg;

endmodule

//--- testbench/setsel_props.sv
// Checker of the profile selector behaviour at its ports.
module setsel_props
   import setsel_pkg::*;
#(
   parameter int NPROF = 8
) (
   input wire logic        REF_CLK,
   input wire logic        RST,
   input wire logic [7:0]  REQ_IN,
   input wire logic        WB_CYC_I,
   input wire logic        WB_STB_I,
   input wire logic        WB_WE_I,
   input wire logic [7:0]  WB_ADR_I,
   input wire logic [3:0]  WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic        WB_ACK_O,
   input wire logic [3:0]  ACTIVE_PROFILE,
   input wire logic [7:0]  ACTIVE_ONEHOT,
   input wire logic [7:0]  PROFILE_ENABLED,
   input wire logic [7:0]  LOAD_DEFAULTS,
   input wire logic        REQUEST_FAIL,
   input wire logic        OVERRIDE_ACTIVE
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);

   ack_once_a: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack held too long");
   ack_delay_a: assert property
      (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
      else $error("ack not one cycle after request");
   reset_state_a: assert property (disable iff (1'b0)
      RST |=> ACTIVE_PROFILE == 4'h1 && !OVERRIDE_ACTIVE)
      else $error("wrong state after reset");
   one_active_a: assert property ($onehot(ACTIVE_ONEHOT))
      else $error("not one profile active");
   onehot_match_a: assert property (
      ACTIVE_ONEHOT == 8'h01 << (ACTIVE_PROFILE - 4'h1))
      else $error("one-hot and number disagree");
   enabled_prefix_a: assert property (PROFILE_ENABLED[0] &&
      (PROFILE_ENABLED & (PROFILE_ENABLED + 8'h01)) == 8'h00)
      else $error("enabled mask not a prefix");
   load_new_a: assert property (
      LOAD_DEFAULTS == (PROFILE_ENABLED & ~$past(PROFILE_ENABLED)))
      else $error("load pulse mismatch");
   quiet_hold_a: assert property (
      ($stable(REQ_IN) && !WB_CYC_I)[*3] |-> $stable(ACTIVE_PROFILE))
      else $error("profile moved without a request");
   override_hold_a: assert property (
      (OVERRIDE_ACTIVE && !WB_CYC_I)[*3] |-> $stable(ACTIVE_PROFILE))
      else $error("profile moved under override");
   fail_keep_a: assert property (
      REQUEST_FAIL |-> $stable(ACTIVE_PROFILE))
      else $error("refused request moved profile");

   fail_c: cover property (REQUEST_FAIL);
   load_c: cover property (LOAD_DEFAULTS != 8'h00);
   release_c: cover property ($fell(OVERRIDE_ACTIVE));
endmodule

bind setsel_top setsel_props #(.NPROF(NPROF)) u_props (
   .REF_CLK(REF_CLK),
   .RST(RST),
   .REQ_IN(REQ_IN),
   .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I),
   .WB_WE_I(WB_WE_I),
   .WB_ADR_I(WB_ADR_I),
   .WB_SEL_I(WB_SEL_I),
   .WB_DAT_I(WB_DAT_I),
   .WB_DAT_O(WB_DAT_O),
   .WB_ACK_O(WB_ACK_O),
   .ACTIVE_PROFILE(ACTIVE_PROFILE),
   .ACTIVE_ONEHOT(ACTIVE_ONEHOT),
   .PROFILE_ENABLED(PROFILE_ENABLED),
   .LOAD_DEFAULTS(LOAD_DEFAULTS),
   .REQUEST_FAIL(REQUEST_FAIL),
   .OVERRIDE_ACTIVE(OVERRIDE_ACTIVE)
);

//--- testbench/setsel_app_model.sv
// Model of the relay logic and inputs that drive the request lines.
module setsel_app_model (
   input  wire logic       clk,
   input  wire logic [7:0] lvl,
   input  wire logic [7:0] pls,
   output logic      [7:0] req
);
   timeunit 1ns;
   timeprecision 1ps;
   // Levels stay until changed; pulses last one cycle.
   initial req = 8'h00;
   always @(posedge clk)
      req <= lvl | pls;
endmodule

//--- testbench/setsel_tb.sv
// Self-checking bench of the parameter profile selector.
`include "setsel_params.svh"

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import setsel_pkg::*;
   localparam logic [7:0] a_en  = `SETSEL_OFS_OVR_EN;
   localparam logic [7:0] a_fs  = `SETSEL_OFS_OVR_SEL;
   localparam logic [7:0] a_cnt = `SETSEL_OFS_COUNT;
   localparam logic [7:0] a_rem = `SETSEL_OFS_REMOTE_SEL;
   localparam logic [7:0] a_loc = `SETSEL_OFS_LOCAL_SEL;
   localparam logic [7:0] a_act = `SETSEL_OFS_ACTIVE;
   localparam logic [7:0] a_st  = `SETSEL_OFS_STATUS;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  lvl = 8'h00;
   logic [7:0]  pls = 8'h00;
   logic [7:0]  req_in;
   logic        wb_cyc = 1'b0;
   logic        wb_stb = 1'b0;
   logic        wb_we = 1'b0;
   logic [7:0]  wb_adr = 8'h00;
   logic [3:0]  wb_sel = 4'h0;
   logic [31:0] wb_dat = 32'h0000_0000;
   logic [31:0] dat_o;
   logic        ack_o;
   logic [31:0] exp_q[$];
   logic [31:0] exp_v;
   logic [3:0]  act_pin;
   logic [2:0]  p;
   int          miscompares = 0;
   int          compares = 0;
   int          cycles = 0;
   int          seed = 18;
   int          k;

   always #2.5 ref_clk = ~ref_clk;

   setsel_app_model u_app (
      .clk(ref_clk),
      .lvl(lvl),
      .pls(pls),
      .req(req_in)
   );
   setsel_top #(.NPROF(8)) uut (
      .REF_CLK(ref_clk),
      .RST(rst),
      .REQ_IN(req_in),
      .WB_CYC_I(wb_cyc),
      .WB_STB_I(wb_stb),
      .WB_WE_I(wb_we),
      .WB_ADR_I(wb_adr),
      .WB_SEL_I(wb_sel),
      .WB_DAT_I(wb_dat),
      .WB_DAT_O(dat_o),
      .WB_ACK_O(ack_o),
      .ACTIVE_PROFILE(act_pin),
      .ACTIVE_ONEHOT(),
      .PROFILE_ENABLED(),
      .LOAD_DEFAULTS(),
      .REQUEST_FAIL(),
      .OVERRIDE_ACTIVE()
   );

   task automatic report_and_stop();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] d);
      @(posedge ref_clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat <= d;
      wb_sel <= 4'h1;
      @(posedge ref_clk);
      while (ack_o !== 1'b1)
         @(posedge ref_clk);
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      wb(1'b1, a, {16'h0000, d});
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      exp_q.push_back({16'h0000, e});
      wb(1'b0, a, 32'h0000_0000);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic pulse(input logic [7:0] m);
      @(posedge ref_clk);
      pls <= m;
      @(posedge ref_clk);
      pls <= 8'h00;
      idle(4);
   endtask

   task automatic setl(input logic [7:0] m);
      @(posedge ref_clk);
      lvl <= m;
      idle(4);
   endtask

   always @(posedge ref_clk)
      if (ack_o === 1'b1 && wb_we === 1'b0)
      begin
         exp_v = exp_q.pop_front();
         chk(dat_o, exp_v);
         if (wb_adr == a_act)
            chk(32'(act_pin), exp_v);
      end

   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles > 20000)
      begin
         miscompares++;
         report_and_stop();
      end
   end

   initial
   begin
      idle(8);
      rst <= 1'b0;
      idle(1);
      rd(a_act, 16'h0001);
      rd(a_fs, 16'h0000);
      rd(a_en, 16'h0000);
      rd(a_cnt, 16'h0000);
      rd(a_st, 16'h0100);
      rd(8'h1C, 16'h0000);
      pulse(8'h04);
      rd(a_act, 16'h0001);
      rd(a_st, 16'h0101);
      wr(a_st, 16'h0007);
      wr(a_cnt, 16'h0007);
      idle(3);
      rd(a_st, 16'hFF00);
      pulse(8'h04);
      rd(a_act, 16'h0003);
      setl(8'h12);
      rd(a_act, 16'h0002);
      pulse(8'h20);
      rd(a_st, 16'hFF04);
      wr(a_st, 16'h0007);
      pulse(8'h01);
      rd(a_act, 16'h0001);
      setl(8'h00);
      setl(8'h80);
      pulse(8'h08);
      rd(a_act, 16'h0004);
      setl(8'h01);
      pulse(8'h04);
      rd(a_act, 16'h0001);
      rd(a_st, 16'hFF04);
      wr(a_st, 16'h0007);
      setl(8'h00);
      wr(a_rem, 16'h0005);
      rd(a_act, 16'h0001);
      rd(a_st, 16'hFF02);
      wr(a_st, 16'h0007);
      wr(a_en, 16'h0001);
      wr(a_rem, 16'h0005);
      rd(a_act, 16'h0005);
      pulse(8'h02);
      rd(a_act, 16'h0005);
      rd(a_st, 16'hFF00);
      wr(a_loc, 16'h0006);
      rd(a_act, 16'h0006);
      wr(a_fs, 16'h0007);
      rd(a_act, 16'h0007);
      rd(a_fs, 16'h0007);
      setl(8'h04);
      wr(a_rem, 16'h0006);
      rd(a_act, 16'h0007);
      rd(a_st, 16'hFF04);
      wr(a_st, 16'h0007);
      wr(a_en, 16'h0000);
      idle(3);
      rd(a_act, 16'h0003);
      setl(8'h00);
      wr(a_en, 16'h0001);
      wr(a_fs, 16'h0006);
      wr(a_en, 16'h0000);
      idle(3);
      rd(a_act, 16'h0006);
      wr(a_cnt, 16'h0001);
      wr(a_en, 16'h0001);
      wr(a_fs, 16'h0005);
      rd(a_act, 16'h0006);
      rd(a_st, 16'h0301);
      wr(a_en, 16'h0000);
      wr(a_st, 16'h0007);
      wr(a_cnt, 16'h0007);
      idle(3);
      for (int i = 0; i < 8; i++)
      begin
         k = $random(seed);
         p = k[2:0];
         pulse(8'h01 << p);
         rd(a_act, 16'(p) + 16'h0001);
      end
      idle(4);
      report_and_stop();
   end
endmodule
